//--- hdl/move_multiply_negate_exec.sv
// four-phase execution of literal load, store, multiply and negate
// Functional notes
// - opcode 0Eh with a literal loads the literal into the accumulator, flags kept.
// - opcode 0110 111a stores the accumulator into the file register, flags kept.
// - the 8-bit file field reaches every byte of a 256-byte bank.
// - bank bit clear selects the access bank, set uses the bank pointer register.
// - bank bit clear with extended set on and file up to 5Fh uses indexed offset.
// - opcode 0Dh multiplies accumulator by literal into the product pair.
// - opcode 0000 001a multiplies accumulator by a file register, both unchanged.
// - both multiplies leave every status flag alone, even on a zero product.
// - opcode 0110 110a negates the file register and updates N, OV, C, DC, Z.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "exec_defs.svh"

module move_multiply_negate_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    output logic instr_ready_o,
    output logic done_o,
    output logic [11:0] mem_addr_o,
    output logic mem_re_o,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o
);

    // ======================================================================
    // state
    exec_pkg::phase_e phase;
    exec_pkg::op_e op;
    exec_pkg::op_e next_op;
    logic [7:0] literal;
    logic [7:0] file_field;
    logic bank_sel;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [7:0] product_low_byte;
    logic [7:0] product_high_byte;
    logic [4:0] status;
    logic [3:0] bank_pointer_register;
    logic [11:0] index_pointer;
    logic ext_set_en;
    logic last_indexed;
    logic [11:0] eff_addr;
    logic eff_indexed;
    logic [15:0] product;
    logic [7:0] negated;
    logic [4:0] neg_flags;
    logic take;
    logic uses_file;

    // ======================================================================
    // decode
    always_comb begin
        next_op = exec_pkg::op_none;
        if (instr_i[15:8] == `OPC_LOAD_LIT) begin
            next_op = exec_pkg::load_literal_to_acc;
        end else if (instr_i[15:8] == `OPC_MUL_LIT) begin
            next_op = exec_pkg::multiply_acc_by_literal;
        end else if (instr_i[15:9] == `OPC_MUL_FILE) begin
            next_op = exec_pkg::multiply_acc_by_file;
        end else if (instr_i[15:9] == `OPC_STORE) begin
            next_op = exec_pkg::store_acc_to_file;
        end else if (instr_i[15:9] == `OPC_NEGATE) begin
            next_op = exec_pkg::negate_file_register;
        end
    end

    assign take = ce_i && instr_ready_o && instr_valid_i;
    assign uses_file = (op == exec_pkg::store_acc_to_file)
        || (op == exec_pkg::multiply_acc_by_file)
        || (op == exec_pkg::negate_file_register);

    // ======================================================================
    // datapath helpers
    file_address_gen u_addr (
        .bank_sel_i(bank_sel),
        .file_i(file_field),
        .bank_pointer_i(bank_pointer_register),
        .ext_set_en_i(ext_set_en),
        .index_pointer_i(index_pointer),
        .addr_o(eff_addr),
        .indexed_o(eff_indexed)
    );

    mult_negate_unit u_alu (
        .acc_i(acc),
        .operand_i(operand),
        .product_o(product),
        .negated_o(negated),
        .neg_flags_o(neg_flags)
    );

    // ======================================================================
    // phase sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= exec_pkg::ph_idle;
        end else if (ce_i) begin
            unique case (phase)
                exec_pkg::ph_idle: begin
                    if (take) begin
                        phase <= exec_pkg::ph_decode;
                    end
                end
                exec_pkg::ph_decode: begin
                    phase <= exec_pkg::ph_read;
                end
                exec_pkg::ph_read: begin
                    phase <= exec_pkg::ph_process;
                end
                exec_pkg::ph_process: begin
                    phase <= exec_pkg::ph_write;
                end
                exec_pkg::ph_write: begin
                    phase <= exec_pkg::ph_idle;
                end
                default: begin
                    phase <= exec_pkg::ph_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            instr_ready_o <= 1'b0;
        end else if (ce_i) begin
            // one instruction in flight; ready returns after the write phase
            if (take) begin
                instr_ready_o <= 1'b0;
            end else if (phase == exec_pkg::ph_idle) begin
                instr_ready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= (phase == exec_pkg::ph_write);
        end
    end

    // ======================================================================
    // instruction capture
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            op <= exec_pkg::op_none;
            literal <= `RST_BYTE;
            file_field <= `RST_BYTE;
            bank_sel <= 1'b0;
        end else if (take) begin
            op <= next_op;
            literal <= instr_i[7:0];
            file_field <= instr_i[7:0];
            bank_sel <= instr_i[8];
        end
    end

    // ======================================================================
    // data memory access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_addr_o <= 12'h000;
            last_indexed <= 1'b0;
        end else if (ce_i && phase == exec_pkg::ph_decode) begin
            mem_addr_o <= eff_addr;
            last_indexed <= eff_indexed;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_re_o <= 1'b0;
        end else if (ce_i) begin
            mem_re_o <= (phase == exec_pkg::ph_decode) && uses_file;
        end
    end

    // read data stand only in the process phase, so the alu takes them
    // straight from the port; a register here would lag one cycle behind
    assign operand = (op == exec_pkg::multiply_acc_by_literal) ? literal
        : mem_rdata_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_we_o <= 1'b0;
            mem_wdata_o <= `RST_BYTE;
        end else if (ce_i) begin
            mem_we_o <= 1'b0;
            if (phase == exec_pkg::ph_process) begin
                if (op == exec_pkg::store_acc_to_file) begin
                    mem_we_o <= 1'b1;
                    mem_wdata_o <= acc;
                end else if (op == exec_pkg::negate_file_register) begin
                    mem_we_o <= 1'b1;
                    mem_wdata_o <= negated;
                end
            end
        end
    end

    // ======================================================================
    // core registers; the process phase wins over a software write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc <= `RST_BYTE;
        end else if (ce_i) begin
            if (phase == exec_pkg::ph_process
                && op == exec_pkg::load_literal_to_acc) begin
                acc <= literal;
            end else if (reg_we_i && reg_addr_i == `REG_ACC) begin
                acc <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            product_low_byte <= `RST_BYTE;
            product_high_byte <= `RST_BYTE;
        end else if (ce_i) begin
            if (phase == exec_pkg::ph_process
                && (op == exec_pkg::multiply_acc_by_literal
                || op == exec_pkg::multiply_acc_by_file)) begin
                product_low_byte <= product[7:0];
                product_high_byte <= product[15:8];
            end else begin
                if (reg_we_i && reg_addr_i == `REG_PROD_LO) begin
                    product_low_byte <= reg_wdata_i;
                end
                if (reg_we_i && reg_addr_i == `REG_PROD_HI) begin
                    product_high_byte <= reg_wdata_i;
                end
            end
        end
    end

    // multiplies, loads and stores never reach this block, so flags hold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= `RST_STATUS;
        end else if (ce_i) begin
            if (phase == exec_pkg::ph_process
                && op == exec_pkg::negate_file_register) begin
                status <= neg_flags;
            end else if (reg_we_i && reg_addr_i == `REG_STATUS) begin
                status <= reg_wdata_i[4:0];
            end
        end
    end

    // ======================================================================
    // addressing configuration, software only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_pointer_register <= `RST_BANK;
            index_pointer <= `RST_INDEX;
            ext_set_en <= `RST_EXT_EN;
        end else if (ce_i && reg_we_i) begin
            if (reg_addr_i == `REG_BANK) begin
                bank_pointer_register <= reg_wdata_i[3:0];
            end
            if (reg_addr_i == `REG_INDEX_LO) begin
                index_pointer[7:0] <= reg_wdata_i;
            end
            if (reg_addr_i == `REG_INDEX_HI) begin
                index_pointer[11:8] <= reg_wdata_i[3:0];
            end
            if (reg_addr_i == `REG_CTRL) begin
                ext_set_en <= reg_wdata_i[`CTRL_EXT_EN];
            end
        end
    end

    // ======================================================================
    // register read port; data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= `RST_BYTE;
        end else if (ce_i) begin
            reg_rdata_o <= `RST_BYTE;
            if (reg_re_i) begin
                unique case (reg_addr_i)
                    `REG_ACC: reg_rdata_o <= acc;
                    `REG_PROD_LO: reg_rdata_o <= product_low_byte;
                    `REG_PROD_HI: reg_rdata_o <= product_high_byte;
                    `REG_STATUS: reg_rdata_o <= {3'h0, status};
                    `REG_BANK: reg_rdata_o <= {4'h0, bank_pointer_register};
                    `REG_INDEX_LO: reg_rdata_o <= index_pointer[7:0];
                    `REG_INDEX_HI: reg_rdata_o <= {4'h0, index_pointer[11:8]};
                    `REG_CTRL: reg_rdata_o <= {7'h00, ext_set_en};
                    `REG_EXEC: reg_rdata_o <= {3'h0, last_indexed,
                        op == exec_pkg::op_none, phase};
                    default: reg_rdata_o <= `RST_BYTE;
                endcase
            end
        end
    end

endmodule

//--- include/exec_defs.svh
// constants for the move, multiply and negate execution block
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ==========================================================================
// opcode patterns
`define OPC_LOAD_LIT 8'h0E
`define OPC_MUL_LIT 8'h0D
`define OPC_MUL_FILE 7'h01
`define OPC_STORE 7'h37
`define OPC_NEGATE 7'h36

// ==========================================================================
// file addressing
`define ACCESS_SPLIT 8'h60
`define INDEXED_LIMIT 8'h5F
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hF

// ==========================================================================
// register port offsets
`define REG_ACC 4'h0
`define REG_PROD_LO 4'h1
`define REG_PROD_HI 4'h2
`define REG_STATUS 4'h3
`define REG_BANK 4'h4
`define REG_INDEX_LO 4'h5
`define REG_INDEX_HI 4'h6
`define REG_CTRL 4'h7
`define REG_EXEC 4'h8

// ==========================================================================
// status and control field positions
`define ST_CARRY 0
`define ST_DIGIT_CARRY 1
`define ST_ZERO 2
`define ST_OVERFLOW 3
`define ST_NEGATIVE 4
`define CTRL_EXT_EN 0

// ==========================================================================
// reset values
`define RST_BYTE 8'h00
`define RST_STATUS 5'h00
`define RST_BANK 4'h0
`define RST_INDEX 12'h000
`define RST_EXT_EN 1'b0

`endif

//--- include/exec_pkg.sv
// types shared by the execution block
package exec_pkg;

    // ======================================================================
    // instruction phases, gray coded along the usual path
    typedef enum logic [2:0] {
        ph_idle = 3'b000,
        ph_decode = 3'b001,
        ph_read = 3'b011,
        ph_process = 3'b010,
        ph_write = 3'b110
    } phase_e;

    // ======================================================================
    // decoded operations
    typedef enum logic [2:0] {
        op_none = 3'h0,
        load_literal_to_acc = 3'h1,
        store_acc_to_file = 3'h2,
        multiply_acc_by_literal = 3'h3,
        multiply_acc_by_file = 3'h4,
        negate_file_register = 3'h5
    } op_e;

endpackage

//--- hdl/file_address_gen.sv
// effective data address from the file field, bank bit and pointers
`timescale 1ns/1ps
`include "exec_defs.svh"

module file_address_gen (
    input wire logic bank_sel_i,
    input wire logic [7:0] file_i,
    input wire logic [3:0] bank_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [11:0] index_pointer_i,
    output logic [11:0] addr_o,
    output logic indexed_o
);

    logic [11:0] indexed_addr;

    assign indexed_addr = index_pointer_i + {4'h0, file_i};

    always_comb begin
        indexed_o = 1'b0;
        if (bank_sel_i) begin
            addr_o = {bank_pointer_i, file_i};
        end else if (ext_set_en_i && file_i <= `INDEXED_LIMIT) begin
            // wraps inside the 4 KiB space rather than faulting
            addr_o = indexed_addr;
            indexed_o = 1'b1;
        end else if (file_i < `ACCESS_SPLIT) begin
            addr_o = {`ACCESS_LOW_BANK, file_i};
        end else begin
            addr_o = {`ACCESS_HIGH_BANK, file_i};
        end
    end

endmodule

//--- hdl/mult_negate_unit.sv
// unsigned 8x8 multiplier and two's complement negation with flags
`timescale 1ns/1ps
`include "exec_defs.svh"

module mult_negate_unit (
    input wire logic [7:0] acc_i,
    input wire logic [7:0] operand_i,
    output logic [15:0] product_o,
    output logic [7:0] negated_o,
    output logic [4:0] neg_flags_o
);

    logic [8:0] neg_sum;
    logic [4:0] nib_sum;

    assign product_o = {8'h00, acc_i} * {8'h00, operand_i};
    assign neg_sum = {1'b0, ~operand_i} + 9'h001;
    assign nib_sum = {1'b0, ~operand_i[3:0]} + 5'h01;
    assign negated_o = neg_sum[7:0];

    always_comb begin
        neg_flags_o = 5'h00;
        neg_flags_o[`ST_CARRY] = neg_sum[8];
        neg_flags_o[`ST_DIGIT_CARRY] = nib_sum[4];
        neg_flags_o[`ST_ZERO] = (neg_sum[7:0] == 8'h00);
        // only 80h negates onto itself with a sign change lost
        neg_flags_o[`ST_OVERFLOW] = (operand_i == 8'h80);
        neg_flags_o[`ST_NEGATIVE] = neg_sum[7];
    end

endmodule

//--- test/move_multiply_negate_exec_chk.sv
// assertion checker for the move, multiply and negate execution block
`timescale 1ns/1ps
`include "exec_defs.svh"

module move_multiply_negate_exec_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_ready_o,
    input wire logic done_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic mem_re_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_we_o,
    input wire logic [7:0] mem_wdata_o
);
    // ======================================================================
    // decode of the word offered at the take edge
    logic take;
    logic neg;
    logic rd;
    logic wr;
    logic lit;
    assign take = ce_i && instr_ready_o && instr_valid_i;
    assign neg = instr_i[15:9] == `OPC_NEGATE;
    assign rd = wr || instr_i[15:9] == `OPC_MUL_FILE;
    assign wr = neg || instr_i[15:9] == `OPC_STORE;
    assign lit = instr_i[15:8] == `OPC_LOAD_LIT
        || instr_i[15:8] == `OPC_MUL_LIT;

    // ======================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DONE_LATENCY: assert property (take |=> !done_o [*4] ##1 done_o)
        else $error("done pulse not five cycles after take");
    AST_READY_BUSY: assert property (
        take |=> !instr_ready_o [*5] ##1 instr_ready_o)
        else $error("ready not low for exactly five cycles");
    AST_READ_PHASE: assert property (take |-> ##2 mem_re_o == $past(rd, 2))
        else $error("read strobe wrong in read phase");
    AST_WRITE_PHASE: assert property (take |-> ##4 mem_we_o == $past(wr, 4))
        else $error("write strobe wrong in write phase");
    AST_WRITE_LAST: assert property (mem_we_o |=> !mem_we_o && done_o)
        else $error("write strobe not last phase");
    AST_ADDR_HOLD: assert property (take |-> ##3 $stable(mem_addr_o) [*2])
        else $error("address moved during the instruction");
    AST_NEG_DATA: assert property (
        take && neg |-> ##4 mem_wdata_o == 8'h00 - $past(mem_rdata_i))
        else $error("negate result wrong");
    AST_LIT_NO_MEM: assert property (
        take && lit |=> (!mem_re_o && !mem_we_o) [*5])
        else $error("literal op touched memory");

    COV_NEG: cover property (take && neg);
    COV_STORE: cover property (take && wr && !neg);
    COV_B2B: cover property (done_o ##6 done_o);
endmodule

bind move_multiply_negate_exec move_multiply_negate_exec_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o),
    .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o),
    .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o));

//--- test/move_multiply_negate_exec_tb_top.sv
// self-checking bench for the move, multiply and negate execution block
`timescale 1ns/1ps

module move_multiply_negate_exec_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic instr_ready_o;
    logic done_o;
    logic [11:0] mem_addr_o;
    logic mem_re_o;
    logic [7:0] mem_rdata_i = 8'h00;
    logic mem_we_o;
    logic [7:0] mem_wdata_o;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] mem [4096];
    logic [11:0] last_wa = 12'h000;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    move_multiply_negate_exec i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_ready_o(instr_ready_o), .done_o(done_o),
        .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o),
        .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
        .mem_wdata_o(mem_wdata_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

    always #5 clk_i = ~clk_i;

    // ======================================================================
    // data memory: read data only in the cycle after the strobe, else churn
    always @(posedge clk_i) begin
        if (mem_re_o === 1'b1) begin
            mem_rdata_i <= mem[mem_addr_o];
        end else begin
            mem_rdata_i <= ~mem_rdata_i;
        end
        if (mem_we_o === 1'b1) begin
            mem[mem_addr_o] <= mem_wdata_o;
            last_wa <= mem_addr_o;
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    // ======================================================================
    // tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        chk("register", {8'h00, reg_rdata_o}, {8'h00, exp});
        @(posedge clk_i);
    endtask

    // offers one word, then waits for the completion pulse
    task automatic exec(input logic [15:0] w);
        int n;
        n = 0;
        instr_i <= w;
        instr_valid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (instr_ready_o !== 1'b1 && n < 20);
        instr_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 20);
        chk("done latency", 16'(n), 16'h0005);
    endtask

    task automatic store(input logic [15:0] w, input logic [11:0] ea,
                         input logic [7:0] v);
        exec({8'h0E, v});
        exec(w);
        chk("store address", {4'h0, last_wa}, {4'h0, ea});
        chk("stored byte", {8'h00, mem[ea]}, {8'h00, v});
    endtask

    task automatic neg(input logic [7:0] v, input logic [7:0] r,
                       input logic [7:0] st);
        mem[12'h230] <= v;
        exec(16'h6D30);
        chk("negated byte", {8'h00, mem[12'h230]}, {8'h00, r});
        reg_rd(4'h3, st);
    endtask

    // ======================================================================
    // sequence
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] <= 8'h00;
        end
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        reg_wr(4'hF, 8'hAA);
        reg_rd(4'hF, 8'h00);
        reg_wr(4'h3, 8'h1F);
        exec(16'h0E5A);
        reg_rd(4'h0, 8'h5A);
        reg_rd(4'h3, 8'h1F);
        exec(16'h0EE2);
        exec(16'h0DC4);
        reg_rd(4'h1, 8'h08);
        reg_rd(4'h2, 8'hAD);
        exec(16'h0E00);
        exec(16'h0D37);
        reg_rd(4'h1, 8'h00);
        reg_rd(4'h3, 8'h1F);
        mem[12'h240] <= 8'hB5;
        reg_wr(4'h4, 8'h02);
        exec(16'h0EC4);
        exec(16'h0340);
        reg_rd(4'h1, 8'h94);
        reg_rd(4'h2, 8'h8A);
        reg_rd(4'h0, 8'hC4);
        // clock enable low must block a software write
        ce_i <= 1'b0;
        reg_wr(4'h0, 8'h77);
        ce_i <= 1'b1;
        reg_rd(4'h0, 8'hC4);
        chk("source byte", {8'h00, mem[12'h240]}, 16'h00B5);
        reg_rd(4'h3, 8'h1F);
        reg_wr(4'h5, 8'h23);
        reg_wr(4'h6, 8'h01);
        store(16'h6E20, 12'h020, 8'h11);
        store(16'h6E80, 12'hF80, 8'h22);
        store(16'h6FFF, 12'h2FF, 8'h33);
        reg_wr(4'h7, 8'h01);
        store(16'h6E5F, 12'h182, 8'h44);
        reg_rd(4'h8, 8'h10);
        store(16'h6E60, 12'hF60, 8'h55);
        store(16'h6F10, 12'h210, 8'h66);
        neg(8'h3A, 8'hC6, 8'h10);
        neg(8'h00, 8'h00, 8'h07);
        neg(8'h80, 8'h80, 8'h1A);
        // an unknown word still runs four phases and changes only the exec register's indexed and no-op flags
        exec(16'hF000);
        reg_rd(4'h8, 8'h18);
        reg_rd(4'h0, 8'h66);
        conclude();
    end
endmodule
